// *** rtl/dcf_fifo.sv ***
// dual-clock fifo with configurable crossing depth, clear sync and output register
`timescale 1ns/10ps
`default_nettype none
module dcf_fifo #(
  parameter int DATA_W         = dcf_pkg::DEF_DATA_W,
  parameter int ADDR_W         = dcf_pkg::DEF_ADDR_W,
  parameter int RD_SYNC_STAGES = dcf_pkg::DEF_SYNC_STAGES,
  parameter int WR_SYNC_STAGES = dcf_pkg::DEF_SYNC_STAGES,
  parameter bit CLOCKS_RELATED = dcf_pkg::OPT_FALSE,
  parameter bit WR_CLR_SYNC    = dcf_pkg::OPT_FALSE,
  parameter bit RD_CLR_SYNC    = dcf_pkg::OPT_FALSE,
  parameter bit OUT_REG        = dcf_pkg::OPT_FALSE,
  parameter bit USE_MEM_BLOCK  = dcf_pkg::OPT_FALSE,
  parameter bit OVF_CHECK      = dcf_pkg::OPT_TRUE,
  parameter bit UNF_CHECK      = dcf_pkg::OPT_TRUE,
  parameter bit LOOKAHEAD      = dcf_pkg::OPT_FALSE
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              wr_req,
  input  wire logic [DATA_W-1:0] wr_data,
  output logic                   wr_full,
  input  wire logic              rd_clk,
  input  wire logic              rd_req,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   rd_empty
);
  localparam int PW       = ADDR_W + 1;
  localparam int DEPTH    = 1 << ADDR_W;
  // related clocks take a fixed short crossing, else the configured depth
  localparam int RD_STAGES = CLOCKS_RELATED ? dcf_pkg::FIXED_SYNC_STAGES : RD_SYNC_STAGES;
  localparam int WR_STAGES = CLOCKS_RELATED ? dcf_pkg::FIXED_SYNC_STAGES : WR_SYNC_STAGES;

  logic              wr_rst_n;
  logic              rd_rst_n;
  logic [PW-1:0]     wr_bin;
  logic [PW-1:0]     next_wr_bin;
  logic [PW-1:0]     wr_gray;
  logic [PW-1:0]     next_wr_gray;
  logic              next_wr_full;
  logic              wr_do;
  logic [PW-1:0]     rd_gray_at_wr;
  logic [PW-1:0]     rd_bin;
  logic [PW-1:0]     next_rd_bin;
  logic [PW-1:0]     rd_gray;
  logic [PW-1:0]     next_rd_gray;
  logic              next_rd_empty;
  logic              rd_do;
  logic [PW-1:0]     wr_gray_at_rd;
  logic [DATA_W-1:0] rd_q;
  logic [DATA_W-1:0] next_rd_q;
  logic [DATA_W-1:0] next_rd_data;
  logic [DATA_W-1:0] mem [DEPTH];

  // clear handling per domain
  generate
    if (WR_CLR_SYNC)
    begin : g_wr_clr
      dcf_sync #(.W(1), .STAGES(dcf_pkg::CLR_SYNC_STAGES)) u_wr_clr (
        .clk   (sys_clk),
        .rst_n (nrst),
        .d     (dcf_pkg::CLR_RELEASED),
        .q     (wr_rst_n)
      );
    end
    else
    begin : g_wr_clr_direct
      assign wr_rst_n = nrst;
    end
    if (RD_CLR_SYNC)
    begin : g_rd_clr
      dcf_sync #(.W(1), .STAGES(dcf_pkg::CLR_SYNC_STAGES)) u_rd_clr (
        .clk   (rd_clk),
        .rst_n (nrst),
        .d     (dcf_pkg::CLR_RELEASED),
        .q     (rd_rst_n)
      );
    end
    else
    begin : g_rd_clr_direct
      assign rd_rst_n = nrst;
    end
  endgenerate

  // pointer crossings
  dcf_sync #(.W(PW), .STAGES(RD_STAGES)) u_wptr_to_rd (
    .clk   (rd_clk),
    .rst_n (rd_rst_n),
    .d     (wr_gray),
    .q     (wr_gray_at_rd)
  );

  dcf_sync #(.W(PW), .STAGES(WR_STAGES)) u_rptr_to_wr (
    .clk   (sys_clk),
    .rst_n (wr_rst_n),
    .d     (rd_gray),
    .q     (rd_gray_at_wr)
  );

  // write domain
  always_comb
  begin
    wr_do        = wr_req && !(OVF_CHECK && wr_full);
    next_wr_bin  = wr_bin + {{(PW-1){1'b0}}, wr_do};
    next_wr_gray = next_wr_bin ^ (next_wr_bin >> 1);
    next_wr_full = (next_wr_gray ==
                    {~rd_gray_at_wr[PW-1:PW-2], rd_gray_at_wr[PW-3:0]});
  end

  always_ff @(posedge sys_clk or negedge wr_rst_n)
  begin
    if (!wr_rst_n)
    begin
      wr_bin  <= '0;
      wr_gray <= '0;
      wr_full <= 1'b0;
    end
    else
    begin
      wr_bin  <= next_wr_bin;
      wr_gray <= next_wr_gray;
      wr_full <= next_wr_full;
    end
  end

  // storage; the same array maps onto memory blocks or logic cells
  generate
    if (USE_MEM_BLOCK)
    begin : g_mem_block
      always_ff @(posedge sys_clk)
      begin
        if (wr_do)
        begin
          mem[wr_bin[ADDR_W-1:0]] <= wr_data;
        end
      end
    end
    else
    begin : g_mem_logic
      always_ff @(posedge sys_clk)
      begin
        if (wr_do)
        begin
          mem[wr_bin[ADDR_W-1:0]] <= wr_data;
        end
      end
    end
  endgenerate

  // read domain
  always_comb
  begin
    rd_do         = rd_req && !(UNF_CHECK && rd_empty);
    next_rd_bin   = rd_bin + {{(PW-1){1'b0}}, rd_do};
    next_rd_gray  = next_rd_bin ^ (next_rd_bin >> 1);
    next_rd_empty = (next_rd_gray == wr_gray_at_rd);
    if (LOOKAHEAD)
    begin
      next_rd_q = mem[next_rd_bin[ADDR_W-1:0]];
    end
    else if (rd_do)
    begin
      next_rd_q = mem[rd_bin[ADDR_W-1:0]];
    end
    else
    begin
      next_rd_q = rd_q;
    end
    next_rd_data = OUT_REG ? rd_q : next_rd_q;
  end

  always_ff @(posedge rd_clk or negedge rd_rst_n)
  begin
    if (!rd_rst_n)
    begin
      rd_bin   <= '0;
      rd_gray  <= '0;
      rd_empty <= 1'b1;
      rd_q     <= '0;
      rd_data  <= '0;
    end
    else
    begin
      rd_bin   <= next_rd_bin;
      rd_gray  <= next_rd_gray;
      rd_empty <= next_rd_empty;
      rd_q     <= next_rd_q;
      rd_data  <= next_rd_data;
    end
  end

  // checks
  sequence clr_hold_s(logic rn);
    !rn ##1 !rn ##1 rn;
  endsequence

  ovf_block_a: assert property (@(posedge sys_clk) disable iff (!wr_rst_n)
    OVF_CHECK && wr_full && wr_req |=> (wr_bin == $past(wr_bin)))
    else $error("write taken while full");

  unf_block_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n)
    UNF_CHECK && rd_empty && rd_req |=> (rd_bin == $past(rd_bin)))
    else $error("read taken while empty");

  wr_gray_a: assert property (@(posedge sys_clk) disable iff (!wr_rst_n)
    $onehot0(wr_gray ^ $past(wr_gray)) && (wr_gray == (wr_bin ^ (wr_bin >> 1))))
    else $error("write pointer not gray stepped");

  rd_gray_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n)
    $onehot0(rd_gray ^ $past(rd_gray)) && (rd_gray == (rd_bin ^ (rd_bin >> 1))))
    else $error("read pointer not gray stepped");

  out_reg_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n)
    OUT_REG && $past(rd_rst_n) |-> (rd_data == $past(rd_q)))
    else $error("output register latency wrong");

  out_direct_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n)
    !OUT_REG |-> (rd_data == rd_q))
    else $error("unregistered output lags");

  lookahead_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n)
    LOOKAHEAD && !rd_empty && !rd_req |=> (rd_q == mem[rd_bin[ADDR_W-1:0]]))
    else $error("head word not shown");

  wr_clr_a: assert property (@(posedge sys_clk)
    WR_CLR_SYNC && $rose(nrst) |-> clr_hold_s(wr_rst_n))
    else $error("write clear release not synchronised");

  rd_clr_a: assert property (@(posedge rd_clk)
    RD_CLR_SYNC && $rose(nrst) |-> clr_hold_s(rd_rst_n))
    else $error("read clear release not synchronised");
endmodule : dcf_fifo
`default_nettype wire

// *** rtl/dcf_pkg.sv ***
// constants shared by the dual-clock fifo and its synchroniser chains
package dcf_pkg;
  localparam int   DEF_DATA_W       = 8;
  localparam int   DEF_ADDR_W       = 4;
  localparam int   DEF_SYNC_STAGES  = 3;
  localparam int   FIXED_SYNC_STAGES = 1;
  localparam int   CLR_SYNC_STAGES  = 2;
  localparam bit   OPT_FALSE        = 1'b0;
  localparam bit   OPT_TRUE         = 1'b1;
  localparam logic CLR_RELEASED     = 1'b1;
endpackage : dcf_pkg

// *** rtl/dcf_sync.sv ***
// multi-stage synchroniser chain with asynchronous clear to zero
`timescale 1ns/10ps
`default_nettype none
module dcf_sync #(
  parameter int W      = 1,
  parameter int STAGES = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] chain      [STAGES];
  logic [W-1:0] next_chain [STAGES];
  int unsigned  warm;
  int unsigned  next_warm;

  always_comb
  begin
    next_chain[0] = d;
    for (int i = 1; i < STAGES; i++)
    begin
      next_chain[i] = chain[i-1];
    end
    next_warm = (warm < STAGES) ? warm + 1 : warm;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < STAGES; i++)
      begin
        chain[i] <= '0;
      end
      warm <= 0;
    end
    else
    begin
      chain <= next_chain;
      warm  <= next_warm;
    end
  end

  assign q = chain[STAGES-1];

  // output is the input delayed by exactly the configured stage count
  sync_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
    (warm >= STAGES) |-> (q == $past(d, STAGES)))
    else $error("synchroniser delay differs from stage count");
endmodule : dcf_sync
`default_nettype wire

// *** testbench/dcf_reader.sv ***
// read-side user model: makes the read clock and consumes words
`timescale 1ns/10ps
`default_nettype none
module dcf_reader #(
  parameter int DW   = 8,
  parameter bit OREG = 1'b0
) (
  input  wire logic          nrst,
  input  wire logic          en,
  input  wire logic          rnd,
  input  wire logic          rd_empty,
  input  wire logic [DW-1:0] rd_data,
  output logic               rd_clk,
  output logic               rd_req,
  output logic               got,
  output logic      [DW-1:0] got_word
);
  logic took;
  logic took_d;
  initial
  begin
    rd_clk = 1'b0;
    forever #3.5 rd_clk = ~rd_clk;
  end
  // strobes are offered even while empty, to probe the refusal
  always @(posedge rd_clk or negedge nrst)
    if (!nrst)
    begin
      rd_req <= 1'b0;
      took <= 1'b0;
      took_d <= 1'b0;
      got <= 1'b0;
      got_word <= '0;
    end
    else
    begin
      rd_req <= en & rnd;
      took <= rd_req & ~rd_empty;
      took_d <= took;
      got <= OREG ? took_d : took;
      got_word <= rd_data;
    end
endmodule : dcf_reader
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the dual-clock fifo
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int DW = 8;
  localparam int DEPTH = 16;
  logic          sys_clk = 1'b0;
  logic          nrst = 1'b0;
  logic          wr_req = 1'b0;
  logic          en = 1'b0;
  logic          rnd = 1'b0;
  logic [DW-1:0] wr_data = '0;
  logic          wr_full, rd_clk, rd_req, rd_empty, got;
  logic [DW-1:0] rd_data, got_word;
  logic [31:0]   seed = 32'hF2E1;
  logic [DW-1:0] exp_q[$];
  logic          wr_full2, rd_clk2, rd_req2, rd_empty2, got2;
  logic [DW-1:0] rd_data2, got_word2;
  logic [DW-1:0] exp_q2[$];
  int            fails = 0;
  int            checks = 0;
  always #5 sys_clk = ~sys_clk;
  dcf_fifo #(.DATA_W(DW), .ADDR_W(4)) dcf_fifo_inst (.sys_clk(sys_clk), .nrst(nrst),
    .wr_req(wr_req), .wr_data(wr_data), .wr_full(wr_full), .rd_clk(rd_clk),
    .rd_req(rd_req), .rd_data(rd_data), .rd_empty(rd_empty));
  dcf_reader #(.DW(DW)) dcf_reader_inst (.nrst(nrst), .en(en), .rnd(rnd),
    .rd_empty(rd_empty), .rd_data(rd_data), .rd_clk(rd_clk), .rd_req(rd_req),
    .got(got), .got_word(got_word));
  // second copy with registered output, clear synchronisers and block storage
  dcf_fifo #(.DATA_W(DW), .ADDR_W(4), .CLOCKS_RELATED(1'b0), .OUT_REG(1'b1),
    .WR_CLR_SYNC(1'b1), .RD_CLR_SYNC(1'b1), .USE_MEM_BLOCK(1'b1)) dcf_fifo_inst2 (
    .sys_clk(sys_clk), .nrst(nrst), .wr_req(wr_req), .wr_data(wr_data), .wr_full(wr_full2),
    .rd_clk(rd_clk2), .rd_req(rd_req2), .rd_data(rd_data2), .rd_empty(rd_empty2));
  dcf_reader #(.DW(DW), .OREG(1'b1)) dcf_reader_inst2 (.nrst(nrst), .en(en), .rnd(rnd),
    .rd_empty(rd_empty2), .rd_data(rd_data2), .rd_clk(rd_clk2), .rd_req(rd_req2),
    .got(got2), .got_word(got_word2));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk_bit(input logic g, input logic e, input string m);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [DW-1:0] g, input logic [DW-1:0] e, input string m);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %0t %s %h %h", $time, m, g, e);
    end
  endtask : chk_word
  task automatic drive(input int n, input bit rand_req);
    for (int i = 0; i < n; i++)
    begin
      @(posedge sys_clk);
      seed = lfsr(seed);
      wr_req <= rand_req ? seed[0] : 1'b1;
      wr_data <= seed[DW+3:4];
      rnd <= seed[9];
    end
    @(posedge sys_clk);
    wr_req <= 1'b0;
  endtask : drive
  task automatic end_of_test();
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // words offered while full are dropped, so they never enter the model
  always @(posedge sys_clk)
    if (nrst && wr_req && wr_full === 1'b0)
      exp_q.push_back(wr_data);
  always @(negedge rd_clk)
    if (got === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk_bit(1'b1, 1'b0, "read from empty");
      else
        chk_word(got_word, exp_q.pop_front(), "read word");
    end
  always @(posedge sys_clk)
    if (nrst && wr_req && wr_full2 === 1'b0)
      exp_q2.push_back(wr_data);
  always @(negedge rd_clk2)
    if (got2 === 1'b1)
    begin
      if (exp_q2.size() == 0)
        chk_bit(1'b1, 1'b0, "read from empty reg");
      else
        chk_word(got_word2, exp_q2.pop_front(), "read word reg");
    end
  initial
  begin
    #200000;
    fails++;
    end_of_test();
  end
  initial
  begin
    repeat (19) @(posedge sys_clk);
    chk_bit(wr_full, 1'b0, "full in reset");
    chk_bit(rd_empty, 1'b1, "empty in reset");
    chk_word(rd_data, '0, "data in reset");
    chk_bit(wr_full2, 1'b0, "full in reset reg");
    chk_bit(rd_empty2, 1'b1, "empty in reset reg");
    chk_word(rd_data2, '0, "data in reset reg");
    @(posedge sys_clk);
    nrst <= 1'b1;
    // synchronised clears hold the logic for two more edges
    repeat (2) @(posedge sys_clk);
    en <= 1'b1;
    drive(20, 1'b0);
    rnd <= 1'b1;
    repeat (30) @(posedge sys_clk);
    en <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk_bit(exp_q.size() == 0, 1'b1, "first drain");
    chk_bit(exp_q2.size() == 0, 1'b1, "first drain reg");
    drive(DEPTH + 6, 1'b0);
    repeat (3) @(posedge sys_clk);
    chk_bit(wr_full, 1'b1, "not full");
    chk_bit(exp_q.size() == DEPTH, 1'b1, "overflow stored");
    chk_bit(wr_full2, 1'b1, "not full reg");
    chk_bit(exp_q2.size() == DEPTH, 1'b1, "overflow stored reg");
    en <= 1'b1;
    drive(200, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      en <= seed[12];
      drive(300, 1'b1);
    end
    en <= 1'b1;
    rnd <= 1'b1;
    repeat (200) @(posedge sys_clk);
    chk_bit(rd_empty, 1'b1, "not drained");
    chk_bit(wr_full, 1'b0, "full after drain");
    chk_bit(exp_q.size() == 0, 1'b1, "words lost");
    chk_bit(rd_empty2, 1'b1, "not drained reg");
    chk_bit(wr_full2, 1'b0, "full after drain reg");
    chk_bit(exp_q2.size() == 0, 1'b1, "words lost reg");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
